// ### hdl/lars_cfg.svh
// Constants for the linear array readout sequencer.
// How it works
// - Five independent 128-pixel sections, 640 pixels, one shared clock.
// - Each section has own start input, end output and pixel output.
// - The one clock steps transfer, pixel output and integrator reset.
// - A start pulse marks the beginning of a section's readout.
// - Each section has a 128-bit shift register plus reset logic.
// - A read cycle starts when start is high at a rising edge.
// - The captured bit advances one stage per clock unless the output stalls, one pixel out each.
// - After a pixel is presented its integrator is reset.
// - End pulse appears on the 129th rising edge after capture unless the output stalls.
// - After its end pulse a section accepts a new start.
// - Parallel mode: each end pulse shows that section's data is done.
// - Last end pulse starts a cascaded device or marks end of array.
// - Pixel output is not driven outside the output phase.
`ifndef LARS_CFG_SVH
`define LARS_CFG_SVH
// ****************************************
// Array geometry
// ****************************************
`define LARS_NSEC     5
`define LARS_NPIX     128
`define LARS_IDX_W    7
`define LARS_LVL_W    10
// ****************************************
// Sequencing
// ****************************************
`define LARS_END_STEP 8'h80
`define LARS_STEP_CAP 8'h01
`define LARS_STEP_W   8
`endif

// ### hdl/lars_pkg.sv
// Types shared by the readout sequencer.
`include "lars_cfg.svh"
package lars_pkg;
    // One pixel sample: index within its section and its charge level
    typedef struct packed {
        logic [`LARS_IDX_W-1:0] idx;
        logic [`LARS_LVL_W-1:0] level;
    } lars_word_t;
endpackage

// ### hdl/lars_top.sv
// Readout sequencer: five sections, their two-entry buffers and the top.
`include "lars_cfg.svh"

// ****************************************
// Two-entry buffer
// ****************************************
module lars_buf2 (
    input  wire logic              sys_clk,   // Clock
    input  wire logic              rst_n,     // Sync reset
    input  wire logic              in_valid,  // Word offered
    input  wire lars_pkg::lars_word_t in_word, // Word in
    output logic                   in_ready,  // Room for a word
    output logic                   out_valid, // Word held
    output lars_pkg::lars_word_t   out_word,  // Oldest word
    input  wire logic              out_ready  // Receiver takes it
);
    import lars_pkg::*;
    logic       full_q;
    lars_word_t d1_q;
    logic       push;
    logic       pop;

    assign in_ready = !full_q;
    assign push     = in_valid && !full_q;
    assign pop      = out_valid && out_ready;

    // Occupancy: empty, one word, or full
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            full_q    <= 1'b0;
        end else begin
            unique case ({push, pop})
                2'b10: begin
                    full_q    <= out_valid;
                    out_valid <= 1'b1;
                end
                2'b01: begin
                    out_valid <= full_q;
                    full_q    <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // Data: head word, and second slot filled only behind a head
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_word <= '0;
            d1_q     <= '0;
        end else begin
            if (pop) begin
                out_word <= full_q ? d1_q : in_word;
            end else if (push && !out_valid) begin
                out_word <= in_word;
            end
            if (push && out_valid && !pop) begin
                d1_q <= in_word;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    buf_no_loss_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        full_q && !out_ready |=> full_q && out_valid)
        else $error("buffer dropped a word while stalled");
    buf_order_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        full_q && pop |=> out_word == $past(d1_q))
        else $error("buffer word order broken");
endmodule

// ****************************************
// One 128-pixel section
// ****************************************
module lars_sect #(
    parameter int NPIX = `LARS_NPIX
) (
    input  wire logic                   sys_clk,   // Shared clock
    input  wire logic                   rst_n,     // Sync reset
    input  wire logic                   start_in,  // Start pulse
    input  wire logic [`LARS_LVL_W-1:0] level_in,  // Selected pixel charge
    input  wire logic                   out_ready, // Receiver ready
    output logic                        out_valid, // Output phase
    output lars_pkg::lars_word_t        out_word,  // Pixel sample
    output logic                        end_out,   // End pulse
    output logic [NPIX-1:0]             select_q,  // Pixel select
    output logic [NPIX-1:0]             integ_rst  // Integrator reset
);
    import lars_pkg::*;
    logic                    busy;
    logic                    adv;
    logic                    cap;
    logic                    in_ready;
    logic [`LARS_IDX_W-1:0]  idx_q;
    logic [`LARS_STEP_W-1:0] step_q;
    lars_word_t              px_word;

    assign busy    = |select_q;
    // A stalled receiver holds the shift so no pixel is lost
    assign adv     = busy && in_ready;
    // Start is only looked at while idle; a start while busy is ignored
    assign cap     = start_in && !busy;
    assign px_word = '{idx: idx_q, level: level_in};

    // Shift register walks the start bit over the pixels
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            select_q <= '0;
        end else if (cap) begin
            select_q <= {{(NPIX-1){1'b0}}, 1'b1};
        end else if (adv) begin
            select_q <= select_q << 1;
        end
    end

    // Pixel index rides alongside the select bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idx_q <= '0;
        end else if (cap) begin
            idx_q <= '0;
        end else if (adv) begin
            idx_q <= idx_q + 1'b1;
        end
    end

    // Reset the integrator of the pixel just read out
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            integ_rst <= '0;
        end else begin
            integ_rst <= adv ? select_q : '0;
        end
    end

    // End pulse as the bit leaves the last stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            end_out <= 1'b0;
        end else begin
            end_out <= adv && select_q[NPIX-1];
        end
    end

    // Output is only driven while a sample is held
    lars_buf2 u_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (busy),
        .in_word   (px_word),
        .in_ready  (in_ready),
        .out_valid (out_valid),
        .out_word  (out_word),
        .out_ready (out_ready)
    );

    // Helper: 1 at capture, then one more per advance
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            step_q <= '0;
        end else if (cap) begin
            step_q <= `LARS_STEP_CAP;
        end else if (adv) begin
            step_q <= step_q + 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    cap_first_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cap |=> select_q[0] && idx_q == '0)
        else $error("start not captured into first stage");
    sel_onehot_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $onehot0(select_q))
        else $error("more than one pixel selected");
    step_shift_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        adv && !select_q[NPIX-1] |=> select_q == $past(select_q) << 1)
        else $error("select did not advance one stage");
    stall_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        busy && !in_ready |=> select_q == $past(select_q))
        else $error("select moved during stall");
    end_count_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        end_out |-> $past(step_q) == `LARS_END_STEP)
        else $error("end pulse not on 129th edge");
    end_single_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        end_out |=> !end_out)
        else $error("end pulse longer than one cycle");
    rearm_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        end_out && start_in |=> select_q[0])
        else $error("start after end pulse not accepted");
    integ_after_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        adv |=> integ_rst == $past(select_q)
            ##1 !(|(integ_rst & $past(integ_rst))))
        else $error("integrator reset not after read");
    // Idle with a ready receiver: the two slots drain within two cycles
    idle_quiet_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !busy && out_ready && !start_in ##1 out_ready && !start_in
        |=> !out_valid)
        else $error("output driven outside output phase");

    cov_full_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cap ##[128:400] end_out);
    cov_stall_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        busy && !in_ready);
    cov_back_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        end_out && start_in);
endmodule

// ****************************************
// Top: five sections on one clock
// ****************************************
module lars_top #(
    parameter int NSEC = `LARS_NSEC,
    parameter int NPIX = `LARS_NPIX
) (
    input  wire logic                   sys_clk,   // Shared clock
    input  wire logic                   rst_n,     // Sync reset
    input  wire logic [NSEC-1:0]        start_in,  // Start per section
    input  wire logic [NSEC-1:0][`LARS_LVL_W-1:0] level_in, // Charge
    input  wire logic [NSEC-1:0]        out_ready, // Receiver ready
    output logic [NSEC-1:0]             pixel_analog_out_en, // Drive en
    output lars_pkg::lars_word_t [NSEC-1:0] pixel_analog_out, // Sample
    output logic [NSEC-1:0]             end_out,   // End pulses
    output logic [NSEC-1:0][NPIX-1:0]   select_q,  // Pixel selects
    output logic [NSEC-1:0][NPIX-1:0]   integ_rst  // Integrator resets
);
    import lars_pkg::*;

    // Sections share only the clock and reset
    for (genvar s = 0; s < NSEC; s++) begin : g_sect
        lars_sect #(.NPIX(NPIX)) u_sect (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .start_in  (start_in[s]),
            .level_in  (level_in[s]),
            .out_ready (out_ready[s]),
            .out_valid (pixel_analog_out_en[s]),
            .out_word  (pixel_analog_out[s]),
            .end_out   (end_out[s]),
            .select_q  (select_q[s]),
            .integ_rst (integ_rst[s])
        );
    end
endmodule

// ### verification/lars_ctrl_model.sv
// Controller model: start pulses, section chaining, receiver readiness.
module lars_ctrl_model #(
    parameter int NSEC = 5
) (
    input  wire logic            sys_clk,   // Shared clock
    input  wire logic            rst_n,     // Sync reset
    input  wire logic [NSEC-1:0] go,        // One-cycle start request
    input  wire logic            serial,    // Chain sections
    input  wire logic            rearm,     // Restart section 0 on its end
    input  wire logic            stall,     // Allow receiver stalls
    input  wire logic [NSEC-1:0] rnd,       // Random ready pattern
    input  wire logic [NSEC-1:0] end_out,   // End pulses
    output logic      [NSEC-1:0] start_in,  // Start pulses
    output logic      [NSEC-1:0] out_ready  // Receiver ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Chained starts ride one-cycle end pulses, so they stay one cycle
    always_comb begin
        start_in = go;
        for (int s = 1; s < NSEC; s++) begin
            start_in[s] = go[s] | (serial & end_out[s-1]);
        end
        start_in[0] = go[0] | (rearm & end_out[0]);
    end

    // Stalls only on request, so unstalled timing stays exact
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_ready <= '0;
        end else begin
            out_ready <= stall ? rnd : '1;
        end
    end
endmodule

// ### verification/tb.sv
// Self-checking bench for the readout sequencer with a reference model.
`include "lars_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lars_pkg::*;
    localparam int NS = `LARS_NSEC;
    localparam int NP = `LARS_NPIX;
    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic [NS-1:0]           go = '0;
    logic [NS-1:0]           rnd = '0;
    logic                    serial = 1'b0;
    logic                    rearm = 1'b0;
    logic                    stall = 1'b0;
    logic [NS-1:0]           start_in, out_ready, en, end_out;
    logic [NS-1:0][9:0]      level_in;
    lars_word_t [NS-1:0]     word;
    logic [NS-1:0][NP-1:0]   sel, irst;
    logic [15:0]             lfsr = 16'h0002;
    logic [9:0]              salt = '0;
    int                      error_cnt = 0;
    int                      compares = 0;
    int                      cyc = 0;
    int                      got[NS], cap[NS], ends[NS], irc[NS];
    bit                      busy[NS];

    // Digital stand-in steps far above the sensor's rated clock
    always #5 sys_clk = ~sys_clk;

    lars_top u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .start_in(start_in),
        .level_in(level_in), .out_ready(out_ready),
        .pixel_analog_out_en(en), .pixel_analog_out(word),
        .end_out(end_out), .select_q(sel), .integ_rst(irst)
    );
    lars_ctrl_model #(.NSEC(NS)) u_ctrl (
        .sys_clk(sys_clk), .rst_n(rst_n), .go(go), .serial(serial),
        .rearm(rearm), .stall(stall), .rnd(rnd), .end_out(end_out),
        .start_in(start_in), .out_ready(out_ready)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [9:0] charge(input int s, input int p);
        return 10'(salt + s * 131 + p * 7);
    endfunction
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] seen);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Sensor stand-in; unselected lines wander so stale data cannot match
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            level_in[s] = lfsr[9:0];
            for (int p = 0; p < NP; p++) begin
                if (sel[s][p]) level_in[s] = charge(s, p);
            end
        end
    end

    // Reference sequencer; end handled before start so end-cycle rearm works
    always @(posedge sys_clk) begin
        cyc++;
        lfsr <= lfsr_next(lfsr);
        rnd <= lfsr[4:0] | lfsr[9:5];
        for (int s = 0; s < NS && rst_n; s++) begin
            if (irst[s] != '0) begin
                check("int_reset_pix", 1, irst[s][irc[s] % NP]);
            end
            irc[s] += $countones(irst[s]);
            if (en[s] && out_ready[s]) begin
                check("idx", got[s] % NP, word[s].idx);
                check("level", charge(s, got[s] % NP), word[s].level);
                got[s]++;
            end
            if (end_out[s]) begin
                if (!stall) check("end_gap", 129, cyc - cap[s]);
                busy[s] = 0;
                ends[s]++;
            end
            if (start_in[s] && !busy[s]) begin
                busy[s] = 1;
                cap[s] = cyc;
            end
        end
    end

    // Hang guard well above the longest stalled serial readout
    always @(posedge sys_clk) if (cyc == 20000) begin
        error_cnt++;
        give_verdict();
    end

    // One run of readouts; a second start while busy must be ignored
    task automatic run(input logic [4:0] g, input bit ser, rea, stl);
        int want[NS];
        @(posedge sys_clk);
        salt <= lfsr[9:0];
        serial <= ser;
        rearm <= rea;
        stall <= stl;
        for (int s = 0; s < NS; s++) begin
            want[s] = g[s] + (s == 0 && rea);
            if (ser && s > 0 && want[s-1] > 0) want[s] = 1;
            got[s] = 0;
            ends[s] = 0;
            irc[s] = 0;
        end
        @(posedge sys_clk);
        go <= g;
        @(posedge sys_clk);
        go <= '0;
        repeat (40) @(posedge sys_clk);
        go <= g;
        @(posedge sys_clk);
        go <= '0;
        forever begin
            @(posedge sys_clk);
            if (ends[0] > 0) rearm <= 1'b0;
            if (en == '0 && sel == '0 && start_in == '0) break;
        end
        // Runs follow back to back: integration time is not modelled
        repeat (2) @(posedge sys_clk);
        for (int s = 0; s < NS; s++) begin
            check("reads", want[s], ends[s]);
            check("samples", want[s] * NP, got[s]);
            check("int_resets", want[s] * NP, irc[s]);
        end
        check("idle_drive", 0, en);
    endtask

    // Reset in mid-read: every section must fall back to idle
    task automatic mid_reset();
        @(posedge sys_clk);
        got[0] = 0;
        irc[0] = 0;
        go <= 5'h01;
        @(posedge sys_clk);
        go <= '0;
        repeat (30) @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int s = 0; s < NS; s++) busy[s] = 0;
        @(posedge sys_clk);
        check("rst_sel", 0, |sel);
        check("rst_irst", 0, |irst);
        check("rst_drive", 0, {en, end_out});
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        run(5'h1f, 0, 0, 0);
        run(5'h01, 0, 1, 0);
        mid_reset();
        run(5'h01, 1, 0, 1);
        run(5'h1f, 0, 0, 1);
        give_verdict();
    end
endmodule
